// File: common/cfg_regs_pkg.sv
// Constants, field positions and carrier types for the configuration option and watchdog registers
package cfg_regs_pkg;

   // ==========================================================
   // Register addresses on the configuration port
   localparam logic [4:0] ADDR_CIPHER_IV  = 5'h0b;   // Cipher chain vector, write only
   localparam logic [4:0] ADDR_IDENTITY   = 5'h0c;   // Identity check gate
   localparam logic [4:0] ADDR_USER_WORD  = 5'h0d;   // User access word
   localparam logic [4:0] ADDR_OPTIONS    = 5'h0e;   // Second options register
   localparam logic [4:0] ADDR_WARM_BOOT  = 5'h10;   // Warm boot start address
   localparam logic [4:0] ADDR_WATCHDOG   = 5'h11;   // Watchdog control

   // ==========================================================
   // Reset values
   localparam logic [31:0] OPTIONS_RESET   = 32'h0000_0000;
   localparam logic [31:0] WARM_BOOT_RESET = 32'h0000_0000;
   localparam logic [31:0] WATCHDOG_RESET  = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

   // Own identity code; the value is arbitrary
   localparam logic [31:0] DEVICE_IDENTITY = 32'h0c5a_7e31;

   // ==========================================================
   // Options register field positions
   localparam int OPT_RETENTION_BIT = 17;
   localparam int OPT_ACTION_HI     = 16;
   localparam int OPT_ACTION_LO     = 15;
   localparam int OPT_PIN_OFF_BIT   = 9;
   localparam int OPT_CHECK_EN_BIT  = 8;
   localparam int OPT_LATENCY_HI    = 3;
   localparam int OPT_LATENCY_LO    = 2;
   localparam int OPT_PAGE_HI       = 1;
   localparam int OPT_PAGE_LO       = 0;

   // Warm boot field positions
   localparam int WB_REVSEL_HI = 31;
   localparam int WB_REVSEL_LO = 30;
   localparam int WB_DRIVE_BIT = 29;
   localparam int WB_ADDR_HI   = 28;

   // Watchdog field positions
   localparam int WD_USER_BIT  = 31;
   localparam int WD_CFG_BIT   = 30;
   localparam int WD_COUNT_HI  = 29;

   // ==========================================================
   // Readback check action codes
   typedef enum logic [1:0] {
      ACT_CONTINUE          = 2'b00,
      ACT_HALT              = 2'b01,
      ACT_CORRECT_CONTINUE  = 2'b10,
      ACT_CORRECT_HALT      = 2'b11
   } check_action_t;

   // Flash page length codes and unit counts
   localparam logic [1:0] PAGE_CODE_ONE   = 2'b00;
   localparam logic [1:0] PAGE_CODE_FOUR  = 2'b01;
   localparam logic [1:0] PAGE_CODE_EIGHT = 2'b10;
   localparam logic [3:0] PAGE_UNITS_ONE   = 4'h1;
   localparam logic [3:0] PAGE_UNITS_FOUR  = 4'h4;
   localparam logic [3:0] PAGE_UNITS_EIGHT = 4'h8;

   // ==========================================================
   // Options presented to the readback checker and flash master
   typedef struct packed {
      logic          retention_release_on_unsync; // Unsync also drops pin retention
      check_action_t readback_check_action;       // Response to a readback error
      logic          readback_error_pin_off;      // Init pin no longer reports errors
      logic          readback_check_enable;       // Continuous background checking
      logic [2:0]    flash_first_read_latency;    // Clocks, 1 to 4
      logic [3:0]    flash_page_length;           // Units, 1, 4 or 8
      logic          flash_page_reserved;         // Reserved page code written
   } options_t;

   // Warm boot request to the fallback sequencer
   typedef struct packed {
      logic        request;   // Reprogram command, registered one cycle late
      logic [28:0] address;   // Start address of the next image
   } boot_req_t;

endpackage : cfg_regs_pkg

// File: dv/cfg_host_model.sv
// Host model that drives the configuration register port and offers frame words
`timescale 1ns/10ps
module cfg_host_model (
   // Clock
   input  wire logic        clk,
   // Register port
   output logic             cfg_wr,
   output logic             cfg_rd,
   output logic [4:0]       cfg_addr,
   output logic [31:0]      cfg_wdata,
   input  wire logic [31:0] cfg_rdata,
   input  wire logic        cfg_rvalid,
   // Frame gate
   output logic             frame_wr,
   input  wire logic        frame_accept,
   input  wire logic        id_error
);
   // ==========================================================
   // Idle bus at time zero
   initial begin
      {cfg_wr, cfg_rd, frame_wr} = 3'h0;
      cfg_addr = 5'h1f;
      cfg_wdata = 32'h5a5a_a5a5;
   end
   // Write one word; data inverted once released
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(negedge clk);
      {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
      @(negedge clk);
      cfg_wr = 1'b0;
      cfg_wdata = ~d;
   endtask
   // Read one word; taken in the cycle valid stands
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic v);
      @(negedge clk);
      {cfg_rd, cfg_addr} = {1'b1, a};
      @(negedge clk);
      cfg_rd = 1'b0;
      d = cfg_rdata;
      v = cfg_rvalid;
   endtask
   // Offer one frame word; the caller proves identity first when it wants acceptance
   task automatic frame(output logic acc, output logic err);
      @(negedge clk);
      frame_wr = 1'b1;
      #1;
      {acc, err} = {frame_accept, id_error};
      @(negedge clk);
      frame_wr = 1'b0;
   endtask
endmodule // cfg_host_model

// File: dv/tb.sv
// Self-checking bench for the configuration option and watchdog register bank
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   import cfg_regs_pkg::*;
   // ==========================================================
   // Clock, reset and design connections
   logic clk = 1'b0, nrst = 1'b0;
   logic cfg_wr, cfg_rd, frame_wr, cfg_rvalid, frame_accept, id_error, cipher_start, retain, init_pin, wd_to;
   logic sync_rel, rb_err, reprog, fb, um, ca, tick, svc;
   logic [4:0]  cfg_addr;
   logic [31:0] cfg_wdata, cfg_rdata, civ, uaw;
   logic [1:0]  rs_o, rs_oe;
   options_t    options;
   boot_req_t   boot_req;
   int          miscompares = 0, n_compared = 0, cyc = 0;
   // Reset read table: address and value
   logic [4:0]  ra [6] = '{ADDR_OPTIONS, ADDR_WARM_BOOT, ADDR_WATCHDOG, ADDR_CIPHER_IV, 5'h1f, ADDR_IDENTITY};
   logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, DEVICE_IDENTITY};
   always #2 clk = ~clk;
   config_option_watchdog_regs DUT (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .frame_wr(frame_wr),
      .frame_accept(frame_accept), .id_error(id_error), .cipher_chain_vector(civ), .cipher_start(cipher_start),
      .user_access_word(uaw), .options(options), .sync_release_command(sync_rel), .config_pin_retention(retain),
      .readback_error(rb_err), .init_error_pin(init_pin), .internal_reprogram_command(reprog),
      .boot_req(boot_req), .revision_select_pins_o(rs_o), .revision_select_pins_oe(rs_oe),
      .fallback_active(fb), .user_mode(um), .config_active(ca), .watchdog_tick(tick),
      .watchdog_service(svc), .watchdog_timeout(wd_to));
   cfg_host_model h (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .frame_wr(frame_wr), .frame_accept(frame_accept),
      .id_error(id_error));
   // ==========================================================
   // Expected option decode
   function automatic options_t eo(logic [31:0] w);
      options_t o;
      o.retention_release_on_unsync = w[17];
      o.readback_check_action = check_action_t'(w[16:15]);
      o.readback_error_pin_off = w[9];
      o.readback_check_enable = w[8];
      o.flash_first_read_latency = {1'b0, w[3:2]} + 3'h1;
      o.flash_page_length = (w[1:0] == 2'b01) ? PAGE_UNITS_FOUR : (w[1:0] == 2'b10) ? PAGE_UNITS_EIGHT : PAGE_UNITS_ONE;
      o.flash_page_reserved = (w[1:0] == 2'b11);
      return o;
   endfunction
   // Expected tick number of the first time-out, zero when none
   function automatic int wd_exp(logic [31:0] w, logic u, logic c, logic f);
      return (!f && ((u && w[31]) || (c && w[30]))) ? int'(w[29:0]) : 0;
   endfunction
   // Verdict and end of run
   task automatic summarize();
      if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] w, d;
      logic        v, a, e;
      int          i, n, hit;
      {sync_rel, rb_err, reprog, fb, um, ca, tick, svc} = 8'h0;
      void'($urandom(32'he2d9));
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      // Reset values, unreadable vector, unmapped read
      for (i = 0; i < 6; i++) begin
         h.rd(ra[i], d, v);
         `CHK({v, d}, {1'b1, rv[i]})
      end
      `CHK({retain, options}, {1'b1, eo(32'h0)})
      // Frame gate closed, wrong identity, then proven
      h.frame(a, e);
      `CHK({a, e}, 2'b01)
      h.wr(ADDR_IDENTITY, DEVICE_IDENTITY ^ 32'h0000_0100);
      h.rd(ADDR_IDENTITY, d, v);
      `CHK(d, DEVICE_IDENTITY)
      h.frame(a, e);
      `CHK({a, e}, 2'b01)
      h.wr(ADDR_IDENTITY, DEVICE_IDENTITY);
      h.frame(a, e);
      `CHK({a, e}, 2'b10)
      // Cipher vector and user word
      w = $urandom;
      h.wr(ADDR_CIPHER_IV, w);
      `CHK({cipher_start, civ}, {1'b1, w})
      w = $urandom;
      h.wr(ADDR_USER_WORD, w);
      h.rd(ADDR_USER_WORD, d, v);
      `CHK({d, uaw}, {w, w})
      // Options: every code first, then random words
      for (i = 0; i < 12; i++) begin
         w = $urandom;
         if (i < 4) w = (w & ~32'h0001_800f) | {15'h0, i[1:0], 11'h0, i[1:0], i[1:0]};
         rb_err = 1'($urandom);
         h.wr(ADDR_OPTIONS, w);
         h.rd(ADDR_OPTIONS, d, v);
         `CHK(options, eo(w))
         `CHK(d & 32'h0003_830f, w & 32'h0003_830f)
         `CHK(init_pin, rb_err & ~w[9])
      end
      // Pin retention kept, then released on unsync
      for (i = 0; i < 2; i++) begin
         h.wr(ADDR_OPTIONS, {14'h0, i[0], 17'h0});
         @(negedge clk);
         sync_rel = 1'b1;
         @(negedge clk);
         sync_rel = 1'b0;
         @(negedge clk);
         `CHK(retain, ~i[0])
      end
      // Warm boot with drivers off and on
      for (i = 0; i < 4; i++) begin
         w = $urandom;
         w[29] = i[0];
         h.wr(ADDR_WARM_BOOT, w);
         h.rd(ADDR_WARM_BOOT, d, v);
         `CHK(d, w)
         @(negedge clk);
         reprog = 1'b1;
         @(negedge clk);
         reprog = 1'b0;
         `CHK(boot_req, {1'b1, w[28:0]})
         `CHK({rs_o, rs_oe}, {w[31:30], {2{w[29]}}})
      end
      // Watchdog: fallback, user and configuration monitoring
      for (i = 0; i < 16; i++) begin
         w = $urandom;
         w[29:0] = 30'(1 + i % 5);
         {um, ca, fb} = 3'($urandom);
         if (i == 0) {w[31:30], um, ca, fb} = 5'h1f;
         if (i == 1) {w[31:30], um, ca, fb} = 5'h14;
         if (i == 2) {w[31:30], w[29:0], um, ca, fb} = {2'b11, 30'h0, 3'b110};
         h.wr(ADDR_WATCHDOG, w);
         h.rd(ADDR_WATCHDOG, d, v);
         `CHK(d, w)
         hit = 0;
         for (n = 1; n <= 8; n++) begin
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
            if (wd_to !== 1'b0 && hit == 0) hit = n;
            @(negedge clk);
         end
         `CHK(hit, wd_exp(w, um, ca, fb))
      end
      // Service in mid-count restarts the watchdog
      {um, ca, fb} = 3'b100;
      h.wr(ADDR_WATCHDOG, {2'b10, 30'h3});
      hit = 0;
      for (n = 1; n <= 6; n++) begin
         tick = 1'b1;
         svc = (n == 2);
         @(negedge clk);
         {tick, svc} = 2'b00;
         if (wd_to !== 1'b0 && hit == 0) hit = n;
         @(negedge clk);
      end
      `CHK(hit, 5)
      summarize();
   end
endmodule // tb

// File: logic/config_option_watchdog_regs.sv
// Configuration option, identity gate, warm boot and watchdog register bank
// Function
// - Identity read returns own fixed code
// - Hold cipher vector to start decryption
// - Store user word, present to fabric
// - Options bit 17 lets unsync drop retention
// - Bits 16:15 select readback error action
// - Bit 9 set stops init pin errors
// - Bit 8 enables continuous readback checking
// - Bits 3:2 set flash first read latency
// - Bits 1:0 set flash page length
// - Reprogram fetches from warm boot address
// - Warm boot bits 31:30 give revision pins
// - Warm boot bit 29 enables revision drivers
// - Warm boot bits 28:0 hold start address
// - Fallback image keeps watchdog disabled
// - Watchdog bit 31 monitors user mode
// - Watchdog bit 30 monitors configuration
// - Watchdog bits 29:0 hold tick count
`timescale 1ns/10ps
module config_option_watchdog_regs (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    nrst,
   // Configuration register port
   input  wire logic                    cfg_wr,          // Write strobe
   input  wire logic                    cfg_rd,          // Read strobe
   input  wire logic [4:0]              cfg_addr,        // Register address
   input  wire logic [31:0]             cfg_wdata,       // Write data
   output logic      [31:0]             cfg_rdata,       // Read data
   output logic                         cfg_rvalid,      // Read data valid
   // Frame data gate
   input  wire logic                    frame_wr,        // Frame data input word offered
   output logic                         frame_accept,    // Word passed to the frame path
   output logic                         id_error,        // Word rejected, identity not proven
   // Cipher engine
   output logic      [31:0]             cipher_chain_vector,
   output logic                         cipher_start,    // New vector loaded
   // Fabric user word
   output logic      [31:0]             user_access_word,
   // Options consumers
   output cfg_regs_pkg::options_t       options,
   input  wire logic                    sync_release_command,
   output logic                         config_pin_retention,
   input  wire logic                    readback_error,  // From the readback checker
   output logic                         init_error_pin,  // Error shown on the init pin
   // Warm boot
   input  wire logic                    internal_reprogram_command,
   output cfg_regs_pkg::boot_req_t      boot_req,
   output logic      [1:0]              revision_select_pins_o,
   output logic      [1:0]              revision_select_pins_oe,
   // Watchdog
   input  wire logic                    fallback_active, // Fallback image loading or running
   input  wire logic                    user_mode,
   input  wire logic                    config_active,
   input  wire logic                    watchdog_tick,   // Slow watchdog clock tick
   input  wire logic                    watchdog_service,
   output logic                         watchdog_timeout
);
   import cfg_regs_pkg::*;

   // ==========================================================
   // Decode helpers

   // Address compare qualified by the write strobe
   function automatic logic wr_hit(input logic [4:0] a);
      return cfg_wr && cfg_addr == a;
   endfunction

   // First read latency in clocks from its code
   function automatic logic [2:0] latency_clocks(input logic [1:0] code);
      return {1'b0, code} + 3'h1;
   endfunction

   // Page length in units from its code; reserved code falls back to one
   function automatic logic [3:0] page_units(input logic [1:0] code);
      unique case (code)
         PAGE_CODE_ONE:   return PAGE_UNITS_ONE;
         PAGE_CODE_FOUR:  return PAGE_UNITS_FOUR;
         PAGE_CODE_EIGHT: return PAGE_UNITS_EIGHT;
         default:         return PAGE_UNITS_ONE;
      endcase
   endfunction

   // ==========================================================
   // Registers
   logic [31:0] cipher_iv_reg;        // Cipher chain vector
   logic        cipher_start_reg;     // Vector load pulse
   logic        id_ok_reg;            // Last identity write matched
   logic [31:0] user_word_reg;        // User access word
   logic [31:0] options_reg;          // Second options register
   logic [31:0] warm_boot_reg;        // Warm boot start address register
   logic [31:0] watchdog_reg;         // Watchdog control
   logic        retention_reg;        // Configuration pin retention held
   logic [1:0]  revsel_reg;           // Revision value latched at reprogram
   logic        revsel_drive_reg;     // Revision drivers on
   logic        boot_req_reg;         // Reprogram request pulse
   logic [28:0] boot_addr_reg;        // Address handed to sequencer
   logic [31:0] rdata_reg;            // Read data
   logic        rvalid_reg;           // Read data valid
   logic        watchdog_en;          // Monitoring in force
   logic        watchdog_restart;     // Counter restart

   // ==========================================================
   // Cipher chain vector, write only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cipher_iv_reg    <= WORD_ZERO;
         cipher_start_reg <= 1'b0;
      end else begin
         cipher_start_reg <= wr_hit(ADDR_CIPHER_IV);
         if (wr_hit(ADDR_CIPHER_IV)) begin
            cipher_iv_reg <= cfg_wdata;
         end
      end
   end

   // ==========================================================
   // Identity gate: a matching write opens, a mismatch closes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         id_ok_reg <= 1'b0;
      end else if (wr_hit(ADDR_IDENTITY)) begin
         id_ok_reg <= cfg_wdata == DEVICE_IDENTITY;
      end
   end

   // Frame data passes only behind a proven identity
   assign frame_accept = frame_wr && id_ok_reg;
   assign id_error     = frame_wr && !id_ok_reg;

   // ==========================================================
   // User access word and options
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         user_word_reg <= WORD_ZERO;
      end else if (wr_hit(ADDR_USER_WORD)) begin
         user_word_reg <= cfg_wdata;
      end
   end

   // Options register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         options_reg <= OPTIONS_RESET;
      end else if (wr_hit(ADDR_OPTIONS)) begin
         options_reg <= cfg_wdata;
      end
   end

   // Options fanned out to readback checker and flash master
   always_comb begin
      options.retention_release_on_unsync = options_reg[OPT_RETENTION_BIT];
      options.readback_check_action = check_action_t'(options_reg[OPT_ACTION_HI:OPT_ACTION_LO]);
      options.readback_error_pin_off = options_reg[OPT_PIN_OFF_BIT];
      options.readback_check_enable  = options_reg[OPT_CHECK_EN_BIT];
      options.flash_first_read_latency = latency_clocks(options_reg[OPT_LATENCY_HI:OPT_LATENCY_LO]);
      options.flash_page_length = page_units(options_reg[OPT_PAGE_HI:OPT_PAGE_LO]);
      options.flash_page_reserved = options_reg[OPT_PAGE_HI] && options_reg[OPT_PAGE_LO];
   end

   // Init pin reports readback errors unless switched off
   assign init_error_pin = readback_error && !options_reg[OPT_PIN_OFF_BIT];

   // ==========================================================
   // Pin retention held until an unsync with release allowed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         retention_reg <= 1'b1;
      end else if (sync_release_command && options_reg[OPT_RETENTION_BIT]) begin
         retention_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Warm boot register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         warm_boot_reg <= WARM_BOOT_RESET;
      end else if (wr_hit(ADDR_WARM_BOOT)) begin
         warm_boot_reg <= cfg_wdata;
      end
   end

   // Reprogram hands address and revision pins to the sequencer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         boot_req_reg     <= 1'b0;
         boot_addr_reg    <= 29'h0000_0000;
         revsel_reg       <= 2'h0;
         revsel_drive_reg <= 1'b0;
      end else begin
         boot_req_reg <= internal_reprogram_command;
         if (internal_reprogram_command) begin
            boot_addr_reg    <= warm_boot_reg[WB_ADDR_HI:0];
            revsel_reg       <= warm_boot_reg[WB_REVSEL_HI:WB_REVSEL_LO];
            revsel_drive_reg <= warm_boot_reg[WB_DRIVE_BIT];
         end
      end
   end

   // ==========================================================
   // Watchdog control and counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         watchdog_reg <= WATCHDOG_RESET;
      end else if (wr_hit(ADDR_WATCHDOG)) begin
         watchdog_reg <= cfg_wdata;
      end
   end

   // Monitoring per phase, never for a fallback image
   assign watchdog_en = !fallback_active &&
                        ((user_mode && watchdog_reg[WD_USER_BIT]) ||
                         (config_active && watchdog_reg[WD_CFG_BIT]));
   assign watchdog_restart = watchdog_service || wr_hit(ADDR_WATCHDOG);

   // Tick counter against the programmed limit
   watchdog_counter u_watchdog (
      .clk     (clk),
      .nrst    (nrst),
      .active  (watchdog_en),
      .restart (watchdog_restart),
      .tick    (watchdog_tick),
      .limit   (watchdog_reg[WD_COUNT_HI:0]),
      .timeout (watchdog_timeout)
   );

   // ==========================================================
   // Read port; write-only and unmapped addresses read zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg  <= WORD_ZERO;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= cfg_rd;
         if (cfg_rd) begin
            unique case (cfg_addr)
               ADDR_IDENTITY:  rdata_reg <= DEVICE_IDENTITY;
               ADDR_USER_WORD: rdata_reg <= user_word_reg;
               ADDR_OPTIONS:   rdata_reg <= options_reg;
               ADDR_WARM_BOOT: rdata_reg <= warm_boot_reg;
               ADDR_WATCHDOG:  rdata_reg <= watchdog_reg;
               default:        rdata_reg <= WORD_ZERO;
            endcase
         end
      end
   end

   // ==========================================================
   // Outputs
   assign cfg_rdata               = rdata_reg;
   assign cfg_rvalid              = rvalid_reg;
   assign cipher_chain_vector     = cipher_iv_reg;
   assign cipher_start            = cipher_start_reg;
   assign user_access_word        = user_word_reg;
   assign config_pin_retention    = retention_reg;
   assign boot_req                = '{request: boot_req_reg, address: boot_addr_reg};
   assign revision_select_pins_o  = revsel_reg;
   assign revision_select_pins_oe = {2{revsel_drive_reg}};

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_identity_read: assert property (cfg_rd && cfg_addr == ADDR_IDENTITY |=> cfg_rdata == DEVICE_IDENTITY)
      else $error("identity read did not return own code");
   a_frame_gate: assert property (frame_wr && !id_ok_reg |-> !frame_accept && id_error)
      else $error("frame data passed without identity");
   a_identity_open: assert property (wr_hit(ADDR_IDENTITY) && cfg_wdata == DEVICE_IDENTITY ##1 frame_wr
                                     |-> frame_accept)
      else $error("matching identity did not open the gate");
   a_identity_late: assert property (wr_hit(ADDR_IDENTITY) && cfg_wdata == DEVICE_IDENTITY
                                     ##1 !wr_hit(ADDR_IDENTITY) ##1 frame_wr |-> frame_accept)
      else $error("proven identity did not hold the gate open");
   a_cipher_hold: assert property (wr_hit(ADDR_CIPHER_IV) |=> cipher_start && cipher_chain_vector == $past(cfg_wdata))
      else $error("cipher vector not loaded");
   a_user_word: assert property (wr_hit(ADDR_USER_WORD) |=> user_access_word == $past(cfg_wdata))
      else $error("user word not updated");
   a_retention_keep: assert property (!options_reg[OPT_RETENTION_BIT] && config_pin_retention
                                      |=> config_pin_retention)
      else $error("retention dropped while release disabled");
   a_init_pin: assert property (init_error_pin == (readback_error && !options.readback_error_pin_off))
      else $error("init pin error use wrong");
   a_boot_addr: assert property (internal_reprogram_command |=> boot_req.request &&
                                 boot_req.address == $past(warm_boot_reg[WB_ADDR_HI:0]))
      else $error("reprogram address wrong");
   a_revsel_drive: assert property (internal_reprogram_command |=> revision_select_pins_oe ==
                                    {2{$past(warm_boot_reg[WB_DRIVE_BIT])}})
      else $error("revision drivers wrong");
   a_fallback_quiet: assert property (fallback_active |-> !watchdog_timeout)
      else $error("watchdog fired during fallback");
   a_latency_map: assert property (options.flash_first_read_latency ==
                                   {1'b0, options_reg[OPT_LATENCY_HI:OPT_LATENCY_LO]} + 3'h1)
      else $error("flash latency mapping wrong");

   c_frame_rejected: cover property (id_error);
   c_frame_accepted: cover property (frame_accept);
   c_reprogram:      cover property (boot_req.request);
   c_watchdog_fire:  cover property (watchdog_timeout);

endmodule // config_option_watchdog_regs

// File: logic/watchdog_counter.sv
// Watchdog time-out counter stepped by slow watchdog clock ticks
`timescale 1ns/10ps
module watchdog_counter (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Control
   input  wire logic        active,        // Monitoring allowed this cycle
   input  wire logic        restart,       // Service or reprogramming of the limit
   input  wire logic        tick,          // One pulse per slow watchdog clock period
   input  wire logic [29:0] limit,         // Time-out count in ticks
   // Result
   output logic             timeout        // One-cycle time-out pulse
);
   import cfg_regs_pkg::*;

   // ==========================================================
   // State
   logic [29:0] count_reg;                  // Ticks seen since last restart
   logic        fired_reg;                  // Time-out already reported

   // Count ticks while active, hold at zero otherwise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= 30'h0000_0000;
      end else if (!active || restart) begin
         count_reg <= 30'h0000_0000;
      end else if (tick && count_reg != limit) begin
         count_reg <= count_reg + 30'h0000_0001;
      end
   end

   // Report each expiry only once until restarted
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fired_reg <= 1'b0;
      end else if (!active || restart) begin
         fired_reg <= 1'b0;
      end else if (timeout) begin
         fired_reg <= 1'b1;
      end
   end

   // A zero limit never expires
   assign timeout = active && !restart && !fired_reg && limit != 30'h0000_0000 && count_reg == limit;

endmodule // watchdog_counter
